// ===== logic/dri_params.svh
`ifndef DRI_PARAMS_SVH
`define DRI_PARAMS_SVH

// register byte offsets
`define DRI_OFF_CTRL     8'h00
`define DRI_OFF_STATUS   8'h04
`define DRI_OFF_REFCNT   8'h08
`define DRI_OFF_MRSCNT   8'h0C
`define DRI_OFF_MR0      8'h10
`define DRI_OFF_MR6      8'h28

// field positions
`define DRI_CTRL_DEBUG   0
`define DRI_ST_READY     3
`define DRI_ST_TMRD      8
`define DRI_ST_IDLE      9
`define DRI_ST_CKE       10

// reset values
`define DRI_CTRL_RST     1'b0
`define DRI_MR_RST       18'h00000

// mode register fields
`define DRI_MR_W         18
`define DRI_MR_NUM       7
`define DRI_MR_SUPPORT   18'h3FFFF
`define DRI_MR3_EXEMPT   18'h00018
`define DRI_MR4_EXEMPT   18'h001C0
`define DRI_MR5_EXEMPT   18'h00007
`define DRI_MR6_EXEMPT   18'h000FF

// timing
`define DRI_CLK_KHZ      125000
`define DRI_IDLE_MS      960
`define DRI_DEBUG_MIN    60
`define DRI_INIT_US      500
`define DRI_TMRD_CK      8

`endif

// ===== logic/dri_pkg.sv
package dri_pkg;
  typedef enum logic [2:0] {
    DRI_ST_RESET   = 3'b000,
    DRI_ST_INTINIT = 3'b001,
    DRI_ST_CKEWAIT = 3'b010,
    DRI_ST_CONFIG  = 3'b011,
    DRI_ST_OPER    = 3'b100
  } dri_state_type;
  typedef logic [17:0] dri_mr_type;
endpackage

// ===== logic/dri_mr_if.sv
interface dri_mr_if;
  import dri_pkg::*;
  logic       wr_en;
  logic [2:0] wr_sel;
  dri_mr_type wr_data;
  dri_mr_type old_data;
  logic [2:0] rd_sel;
  dri_mr_type rd_data;
  modport ctl (output wr_en, output wr_sel, output wr_data, output rd_sel, input old_data, input rd_data);
  modport mrf (input wr_en, input wr_sel, input wr_data, input rd_sel, output old_data, output rd_data);
endinterface

// ===== logic/dri_mr_file.sv
`include "dri_params.svh"

module dri_mr_file #(
  parameter logic [17:0] SUPPORT = `DRI_MR_SUPPORT
) (
  input wire logic hclk,
  input wire logic hresetn,
  dri_mr_if.mrf    mr
);
  import dri_pkg::*;

  dri_mr_type mr_r   [`DRI_MR_NUM];
  dri_mr_type mr_nxt [`DRI_MR_NUM];

  genvar gi;
  generate
    for (gi = 0; gi < `DRI_MR_NUM; gi++) begin : g_mr
      always_comb begin
        mr_nxt[gi] = mr_r[gi];
        if (mr.wr_en && mr.wr_sel == 3'(gi)) begin
          mr_nxt[gi] = mr.wr_data & SUPPORT;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mr_r[gi] <= `DRI_MR_RST;
        end else begin
          mr_r[gi] <= mr_nxt[gi];
        end
      end
    end
  endgenerate

  assign mr.old_data = (mr.wr_sel < 3'd7) ? mr_r[mr.wr_sel] : `DRI_MR_RST;
  assign mr.rd_data  = (mr.rd_sel < 3'd7) ? mr_r[mr.rd_sel] : `DRI_MR_RST;
endmodule // dri_mr_file

// ===== logic/dri_top.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "dri_params.svh"

// Summary of operation
// - reset completion clears all counters except refresh counters; normal operation follows.
// - seven mode registers, written only by the MRS command.
// - MRS accepted during normal operation, updating the addressed register each time.
// - MRS and DLL reset never disturb array contents.
// - settings not needed by the speed bin may be unsupported.
module dri_top #(
  parameter longint     IDLE_CYC   = longint'(`DRI_IDLE_MS) * `DRI_CLK_KHZ,
  parameter longint     DEBUG_CYC  = longint'(`DRI_DEBUG_MIN) * 60 * 1000 * `DRI_CLK_KHZ,
  parameter int         INIT_CYC   = (`DRI_INIT_US * `DRI_CLK_KHZ + 999) / 1000,
  parameter logic [7:0] TMRD_CYC   = 8'(`DRI_TMRD_CK),
  parameter logic [17:0] SUPPORT   = `DRI_MR_SUPPORT
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        dram_reset_n,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        act_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  bg,
  input  wire logic [1:0]  ba,
  input  wire logic [17:0] addr,
  output logic             dram_ready
);
  import dri_pkg::*;

  dri_mr_if mrb ();
  dri_mr_file #(.SUPPORT(SUPPORT)) u_mrf (.hclk(hclk), .hresetn(hresetn), .mr(mrb.mrf));

  // command decode
  logic cmd_mrs, cmd_ref, cmd_zqcl;
  assign cmd_mrs  = cke && !cs_n && act_n && !ras_n && !cas_n && !we_n && !bg[1];
  assign cmd_ref  = cke && !cs_n && act_n && !ras_n && !cas_n && we_n;
  assign cmd_zqcl = cke && !cs_n && act_n && ras_n && cas_n && !we_n && addr[10];

  dri_state_type state_r, state_nxt;
  logic [31:0] init_cnt_r, init_cnt_nxt;
  logic [39:0] idle_cnt_r, idle_cnt_nxt;
  logic [7:0]  gap_r, gap_nxt;
  logic        exempt_r, exempt_nxt;
  logic [31:0] ref_cnt_r, ref_cnt_nxt;
  logic [31:0] mrs_cnt_r, mrs_cnt_nxt;
  logic        cke_q_r, cs_q_r;
  logic        tmrd_err_r, tmrd_err_nxt, idle_err_r, idle_err_nxt, cke_err_r, cke_err_nxt;
  logic        debug_r, debug_nxt;
  logic        mrs_ok;
  logic [39:0] idle_lim;
  dri_mr_type  exempt_mask;

  // bus phase registers
  logic        dp_wr_r, dp_wr_nxt;
  logic [7:0]  dp_addr_r, dp_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic        hreadyout_r, hresp_r, ready_r;
  logic        ap_take;
  logic        st_clr;
  logic [31:0] rd_mux;

  assign mrs_ok       = cmd_mrs && (state_r == DRI_ST_CONFIG || state_r == DRI_ST_OPER) && ba != 2'b11 || 
                        cmd_mrs && (state_r == DRI_ST_CONFIG || state_r == DRI_ST_OPER) && !bg[0];
  assign mrb.wr_en    = mrs_ok;
  assign mrb.wr_sel   = {bg[0], ba};
  assign mrb.wr_data  = addr;
  assign idle_lim     = debug_r ? DEBUG_CYC[39:0] : IDLE_CYC[39:0];
  assign st_clr       = dp_wr_r && dp_addr_r == `DRI_OFF_STATUS;

  always_comb begin
    unique case (mrb.wr_sel)
      3'd3:    exempt_mask = `DRI_MR3_EXEMPT;
      3'd4:    exempt_mask = `DRI_MR4_EXEMPT;
      3'd5:    exempt_mask = `DRI_MR5_EXEMPT;
      3'd6:    exempt_mask = `DRI_MR6_EXEMPT;
      default: exempt_mask = 18'h00000;
    endcase
  end

  // device sequence
  always_comb begin
    state_nxt    = state_r;
    init_cnt_nxt = init_cnt_r;
    idle_cnt_nxt = idle_cnt_r;
    gap_nxt      = (gap_r == 8'hFF) ? gap_r : gap_r + 8'h01;
    exempt_nxt   = exempt_r;
    ref_cnt_nxt  = cmd_ref && state_r != DRI_ST_RESET ? ref_cnt_r + 32'h1 : ref_cnt_r;
    mrs_cnt_nxt  = mrs_ok ? mrs_cnt_r + 32'h1 : mrs_cnt_r;
    // write one to clear first, so a set in the same cycle wins
    tmrd_err_nxt = tmrd_err_r && !(st_clr && hwdata[`DRI_ST_TMRD]);
    idle_err_nxt = idle_err_r && !(st_clr && hwdata[`DRI_ST_IDLE]);
    cke_err_nxt  = cke_err_r && !(st_clr && hwdata[`DRI_ST_CKE]);
    if (mrs_ok) begin
      gap_nxt    = 8'h00;
      exempt_nxt = |((mrb.old_data ^ (addr & SUPPORT)) & exempt_mask);
      if (gap_r < TMRD_CYC - 8'h01 && !exempt_r) begin
        tmrd_err_nxt = 1'b1;
      end
    end
    unique case (state_r)
      DRI_ST_RESET: begin
        init_cnt_nxt = 32'h0;
        state_nxt    = DRI_ST_INTINIT;
      end
      DRI_ST_INTINIT: begin
        init_cnt_nxt = init_cnt_r + 32'h1;
        if (cke) begin
          cke_err_nxt = 1'b1;
        end
        if (init_cnt_r >= 32'(INIT_CYC - 1)) begin
          state_nxt = DRI_ST_CKEWAIT;
        end
      end
      DRI_ST_CKEWAIT: begin
        if (cke) begin
          state_nxt = DRI_ST_CONFIG;
        end
      end
      DRI_ST_CONFIG: begin
        if (cmd_zqcl) begin
          state_nxt    = DRI_ST_OPER;
          idle_cnt_nxt = 40'h0;
        end
      end
      DRI_ST_OPER: begin
        if (cmd_ref || cke != cke_q_r || cs_n != cs_q_r) begin
          idle_cnt_nxt = 40'h0;
        end else if (idle_cnt_r < idle_lim) begin
          idle_cnt_nxt = idle_cnt_r + 40'h1;
        end else begin
          idle_err_nxt = 1'b1;
        end
      end
      default: state_nxt = DRI_ST_RESET;
    endcase
    // warm reset clears the state, idle and mrs counts and mrs spacing; refresh count, error flags and mode registers are kept
    if (!dram_reset_n) begin
      state_nxt    = DRI_ST_RESET;
      idle_cnt_nxt = 40'h0;
      mrs_cnt_nxt  = 32'h0;
      gap_nxt      = 8'hFF;
      exempt_nxt   = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= DRI_ST_RESET;
      init_cnt_r <= 32'h0;
      idle_cnt_r <= 40'h0;
      gap_r      <= 8'hFF;
      exempt_r   <= 1'b0;
      ref_cnt_r  <= 32'h0;
      mrs_cnt_r  <= 32'h0;
      tmrd_err_r <= 1'b0;
      idle_err_r <= 1'b0;
      cke_err_r  <= 1'b0;
      cke_q_r    <= 1'b0;
      cs_q_r     <= 1'b1;
      ready_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      init_cnt_r <= init_cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      gap_r      <= gap_nxt;
      exempt_r   <= exempt_nxt;
      ref_cnt_r  <= ref_cnt_nxt;
      mrs_cnt_r  <= mrs_cnt_nxt;
      tmrd_err_r <= tmrd_err_nxt;
      idle_err_r <= idle_err_nxt;
      cke_err_r  <= cke_err_nxt;
      cke_q_r    <= cke;
      cs_q_r     <= cs_n;
      ready_r    <= (state_nxt == DRI_ST_OPER);
    end
  end

  // ahb-lite slave, zero wait states
  assign ap_take    = hsel && htrans[1] && hready;
  assign mrb.rd_sel = 3'((haddr[7:0] - `DRI_OFF_MR0) >> 2);

  always_comb begin
    rd_mux = 32'h0;
    if (haddr[7:0] == `DRI_OFF_CTRL) begin
      rd_mux[`DRI_CTRL_DEBUG] = debug_r;
    end else if (haddr[7:0] == `DRI_OFF_STATUS) begin
      rd_mux[2:0]           = state_r;
      rd_mux[`DRI_ST_READY] = ready_r;
      rd_mux[`DRI_ST_TMRD]  = tmrd_err_r;
      rd_mux[`DRI_ST_IDLE]  = idle_err_r;
      rd_mux[`DRI_ST_CKE]   = cke_err_r;
    end else if (haddr[7:0] == `DRI_OFF_REFCNT) begin
      rd_mux = ref_cnt_r;
    end else if (haddr[7:0] == `DRI_OFF_MRSCNT) begin
      rd_mux = mrs_cnt_r;
    end else if (haddr[7:0] >= `DRI_OFF_MR0 && haddr[7:0] <= `DRI_OFF_MR6 && haddr[1:0] == 2'b00) begin
      rd_mux = {14'h0, mrb.rd_data};
    end
    if (haddr[31:8] != 24'h0) begin
      rd_mux = 32'h0;
    end
  end

  always_comb begin
    dp_wr_nxt   = ap_take && hwrite && haddr[31:8] == 24'h0;
    dp_addr_nxt = ap_take ? haddr[7:0] : dp_addr_r;
    hrdata_nxt  = (ap_take && !hwrite) ? rd_mux : hrdata_r;
    debug_nxt   = debug_r;
    if (dp_wr_r && dp_addr_r == `DRI_OFF_CTRL) begin
      debug_nxt = hwdata[`DRI_CTRL_DEBUG];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r     <= 1'b0;
      dp_addr_r   <= 8'h00;
      hrdata_r    <= 32'h0;
      debug_r     <= `DRI_CTRL_RST;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      dp_wr_r     <= dp_wr_nxt;
      dp_addr_r   <= dp_addr_nxt;
      hrdata_r    <= hrdata_nxt;
      debug_r     <= debug_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hrdata     = hrdata_r;
  assign hreadyout  = hreadyout_r;
  assign hresp      = hresp_r;
  assign dram_ready = ready_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_oper_after_zq:   assert property ($rose(ready_r) |-> $past(cmd_zqcl))
    else $error("ready without zq calibration");
  a_mrs_writes_reg:  assert property (mrs_ok |=> u_mrf.mr_r[$past(mrb.wr_sel)] == ($past(addr) & SUPPORT))
    else $error("mode register not updated by mrs");
  a_only_mrs_write:  assert property (!(mrs_ok && mrb.wr_sel == 3'd0) |=> u_mrf.mr_r[0] == $past(u_mrf.mr_r[0]))
    else $error("mode register changed without mrs");
  a_reset_clears:    assert property (!dram_reset_n |=> state_r == DRI_ST_RESET && idle_cnt_r == 40'h0 && mrs_cnt_r == 32'h0)
    else $error("warm reset left a counter");
  a_refcnt_kept:     assert property (!dram_reset_n && !cmd_ref |=> ref_cnt_r == $past(ref_cnt_r))
    else $error("refresh count lost in reset");
  a_tmrd_flagged:    assert property (mrs_ok && gap_r < TMRD_CYC - 8'h01 && !exempt_r |=> tmrd_err_r)
    else $error("mrs spacing violation missed");
  a_idle_flagged:    assert property (state_r == DRI_ST_OPER && dram_reset_n && idle_cnt_r >= idle_lim && !cmd_ref
                                      && cke == cke_q_r && cs_n == cs_q_r |=> idle_err_r)
    else $error("idle limit miss not flagged");
  a_cke_early:       assert property (state_r == DRI_ST_INTINIT && cke |=> cke_err_r)
    else $error("early cke not flagged");
  a_no_wait_states:  assert property (hreadyout && !hresp)
    else $error("slave inserted wait or error");

  c_reach_oper:      cover property ($rose(ready_r));
  c_mrs_in_oper:     cover property (mrs_ok && state_r == DRI_ST_OPER);
  c_tmrd_error:      cover property ($rose(tmrd_err_r));
  c_warm_reset:      cover property (state_r == DRI_ST_OPER ##1 !dram_reset_n);
endmodule // dri_top

// ===== tb/dri_ctl_model.sv
module dri_ctl_model #(
  parameter int INIT_CYC = 10,
  parameter int TMRD_CYC = 8
) (
  input  wire logic        hclk,
  output logic             dram_reset_n,
  output logic             cke,
  output logic             cs_n,
  output logic             act_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       bg,
  output logic [1:0]       ba,
  output dri_pkg::dri_mr_type addr
);
  import dri_pkg::*;
  localparam int ORD [7] = '{3, 6, 5, 4, 2, 1, 0};
  initial begin
    {dram_reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n} = 7'h1F;
    {bg, ba, addr} = 22'h0;
  end
  // deselect slots, address lines not held
  task automatic des(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      if (i < n - 1) addr <= ~addr;
    end
  endtask
  task automatic send(input logic [2:0] rcw, input logic [2:0] sel, input dri_mr_type d);
    {cs_n, act_n, ras_n, cas_n, we_n} <= {2'b01, rcw};
    {bg, ba} <= {1'b0, sel};
    addr <= d;
    @(posedge hclk);
    {cs_n, ras_n, cas_n, we_n} <= {1'b1, ~rcw};
    ba <= ~sel[1:0];
    addr <= ~d;
  endtask
  task automatic mrs(input logic [2:0] sel, input dri_mr_type d);
    send(3'b000, sel, d);
    des(TMRD_CYC - 1);
  endtask
  task automatic rst_pulse(input int n);
    cke <= 1'b0;
    @(posedge hclk);
    dram_reset_n <= 1'b0;
    repeat (n) @(posedge hclk);
    dram_reset_n <= 1'b1;
  endtask
  task automatic bring_up(input logic early, input dri_mr_type v [7]);
    cke <= early;
    des(INIT_CYC + 4);
    cke <= 1'b1;
    des(5);
    for (int i = 0; i < 7; i++) mrs(3'(ORD[i]), v[ORD[i]]);
    send(3'b110, 3'h0, 18'h00400);
  endtask
endmodule // dri_ctl_model

// ===== tb/tb.sv
`include "dri_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dri_pkg::*;
  localparam int INIT = 30;
  localparam int TMRD = 8;
  localparam longint IDLE = 200;
  localparam longint DBG = 400;
  localparam logic [17:0] SUP = 18'h1FFFF;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dram_ready;
  logic        dram_reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0]  hsize, s;
  logic [1:0]  htrans, bg, ba;
  dri_mr_type  addr, v;
  dri_mr_type  mr_m [7];
  int          miscompares, checked;
  assign hready = hreadyout;
  dri_top #(.IDLE_CYC(IDLE), .DEBUG_CYC(DBG), .INIT_CYC(INIT), .TMRD_CYC(8'(TMRD)), .SUPPORT(SUP)) u_dri_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .dram_reset_n, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bg, .ba, .addr, .dram_ready);
  dri_ctl_model #(.INIT_CYC(INIT), .TMRD_CYC(TMRD)) u_dri_ctl_model (
    .hclk, .dram_reset_n, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bg, .ba, .addr);
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, $urandom);
    chk(w, rd, exp);
  endtask
  task automatic chk_mrs;
    for (int i = 0; i < 7; i++) rchk("mr", 8'(`DRI_OFF_MR0 + 4 * i), {14'h0, mr_m[i] & SUP});
  endtask
  function automatic logic [31:0] st(input dri_state_type q, input logic [2:0] e);
    return {21'h0, e, 4'h0, q == DRI_ST_OPER, q};
  endfunction
  // two mode register writes a given number of cycles apart
  task automatic pair(input logic [2:0] a, input dri_mr_type va, input int gap, input logic [2:0] b);
    u_dri_ctl_model.send(3'b000, a, va);
    mr_m[a] = va;
    u_dri_ctl_model.des(gap - 1);
    v = 18'($urandom);
    u_dri_ctl_model.mrs(b, v);
    mr_m[b] = v;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    miscompares = 0;
    checked = 0;
    void'($urandom(32'h8A29C89D));
    foreach (mr_m[i]) mr_m[i] = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("ctrl", `DRI_OFF_CTRL, 32'h0);
    rchk("status", `DRI_OFF_STATUS, st(DRI_ST_RESET, 3'h0));
    chk_mrs;
    for (int k = 0; k < 2; k++) begin
      u_dri_ctl_model.rst_pulse(4);
      rchk("mrscnt", `DRI_OFF_MRSCNT, 32'h0);
      rchk("refcnt", `DRI_OFF_REFCNT, 32'(5 * k));
      rchk("status", `DRI_OFF_STATUS, st(DRI_ST_INTINIT, 3'h0));
      chk("ready", {31'h0, dram_ready}, 32'h0);
      chk_mrs;
      foreach (mr_m[i]) mr_m[i] = 18'($urandom);
      u_dri_ctl_model.bring_up(k[0], mr_m);
      rchk("status", `DRI_OFF_STATUS, st(DRI_ST_OPER, {k[0], 2'b00}));
      chk("ready", {31'h0, dram_ready}, 32'h1);
      rchk("mrscnt", `DRI_OFF_MRSCNT, 32'h7);
      chk_mrs;
      if (k == 0) begin
        ahb(1'b1, `DRI_OFF_MR0, 32'h3FFFF);
        rchk("unmapped", 8'h80, 32'h0);
        chk_mrs;
        repeat (6) begin
          s = 3'($urandom_range(6));
          v = 18'($urandom);
          u_dri_ctl_model.mrs(s, v);
          mr_m[s] = v;
          chk_mrs;
        end
        u_dri_ctl_model.mrs(3'h7, 18'($urandom));
        chk_mrs;
        rchk("status", `DRI_OFF_STATUS, st(DRI_ST_OPER, 3'h0));
        pair(3'h1, 18'($urandom), TMRD - 1, 3'h2);
        rchk("status", `DRI_OFF_STATUS, st(DRI_ST_OPER, 3'h1));
        chk_mrs;
        ahb(1'b1, `DRI_OFF_STATUS, 32'h100);
        pair(3'h3, mr_m[3] ^ 18'h00018, 2, 3'h2);
        rchk("status", `DRI_OFF_STATUS, st(DRI_ST_OPER, 3'h0));
        repeat (3) begin
          u_dri_ctl_model.send(3'b001, 3'h0, 18'h0);
          u_dri_ctl_model.des(1);
        end
        rchk("refcnt", `DRI_OFF_REFCNT, 32'h3);
        u_dri_ctl_model.des(int'(IDLE) + 20);
        rchk("status", `DRI_OFF_STATUS, st(DRI_ST_OPER, 3'h2));
        ahb(1'b1, `DRI_OFF_CTRL, 32'h1);
        rchk("ctrl", `DRI_OFF_CTRL, 32'h1);
        u_dri_ctl_model.send(3'b001, 3'h0, 18'h0);
        ahb(1'b1, `DRI_OFF_STATUS, 32'h200);
        u_dri_ctl_model.des(int'(IDLE) + 20);
        rchk("status", `DRI_OFF_STATUS, st(DRI_ST_OPER, 3'h0));
        u_dri_ctl_model.des(int'(DBG - IDLE));
        rchk("status", `DRI_OFF_STATUS, st(DRI_ST_OPER, 3'h2));
        ahb(1'b1, `DRI_OFF_CTRL, 32'h0);
        u_dri_ctl_model.send(3'b001, 3'h0, 18'h0);
        ahb(1'b1, `DRI_OFF_STATUS, 32'h200);
      end
    end
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    report_and_stop;
  end
endmodule // tb
